// >>> src/sya_pkg.sv
// Shared constants, types and register map of the sync activity and area detect block
package sya_pkg;
    // Clock and timing
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int ACT_TIMEOUT_MS = 100;
    localparam int ACT_TIMEOUT_CYC = (CLK_FREQ_HZ / 1000) * ACT_TIMEOUT_MS;
    localparam int ACT_CNT_W = 25;

    // Monitored syncs, in vector order
    localparam int NUM_SYNC = 6;
    localparam int NUM_COMP = 3;
    localparam int COMP_W = 8;
    localparam int COORD_W = 16;

    // Register byte offsets
    localparam logic [7:0] REG_DETECT_CTRL = 8'h00;
    localparam logic [7:0] REG_SYNC_STATUS = 8'h04;
    localparam logic [7:0] REG_SYNC_INT_EN = 8'h08;
    localparam logic [7:0] REG_SYNC_INT_PEND = 8'h0C;
    localparam logic [7:0] REG_INPUT_SYNC_CTRL = 8'h10;
    localparam logic [7:0] REG_ADJUST_CTRL = 8'h14;
    localparam logic [7:0] REG_REF_POS0 = 8'h18;
    localparam logic [7:0] REG_REF_POS1 = 8'h1C;
    localparam logic [7:0] REG_REF_COLOUR0 = 8'h20;
    localparam logic [7:0] REG_REF_COLOUR1 = 8'h24;
    localparam logic [7:0] REG_EVAL0 = 8'h28;
    localparam logic [7:0] REG_EVAL1 = 8'h2C;
    localparam logic [7:0] REG_PIXEL0 = 8'h30;
    localparam logic [7:0] REG_PIXEL1 = 8'h34;

    // Writable bit masks, reserved bits read zero
    localparam logic [31:0] MASK_INT_EN = 32'h0000_003F;
    localparam logic [31:0] MASK_INPUT_SYNC = 32'h0000_0001;
    localparam logic [31:0] MASK_ADJUST = 32'h0000_007F;
    localparam logic [31:0] MASK_REF_POS = 32'h0FFF_07FF;
    localparam logic [31:0] MASK_COLOUR = 32'h00FF_FFFF;

    // Field positions
    localparam int CLEAR_INT_BIT = 0;
    localparam int LOCK_BIT = 6;
    localparam int USE_DE_BIT = 0;
    localparam int FN_LSB = 0;
    localparam int VAR_LSB = 2;
    localparam int IVL_LSB = 4;
    localparam int DONE_EN_BIT = 6;
    localparam int BUSY_BIT = 8;
    localparam int DONE_PEND_BIT = 9;
    localparam int REF_COL_LSB = 0;
    localparam int REF_ROW_LSB = 16;
    localparam int VAR_NONENH_BIT = 0;
    localparam int VAR_INIT_BIT = 1;

    // Interval codes and frame counts
    localparam logic [1:0] IVL_ONE = 2'h0;
    localparam logic [1:0] IVL_FOUR = 2'h1;
    localparam logic [1:0] IVL_EIGHT = 2'h2;
    localparam logic [4:0] FRAMES_1 = 5'h01;
    localparam logic [4:0] FRAMES_4 = 5'h04;
    localparam logic [4:0] FRAMES_8 = 5'h08;
    localparam logic [4:0] FRAMES_16 = 5'h10;

    // Initial and reset values
    localparam logic [15:0] COORD_INIT_UL = 16'hFFFF;
    localparam logic [15:0] COORD_INIT_LR = 16'h0000;
    localparam logic [7:0] COMP_MAX_INIT = 8'h00;
    localparam logic [7:0] COMP_MIN_INIT = 8'hFF;

    typedef enum logic [1:0] {
        FN_AREA = 2'b00,
        FN_MINMAX = 2'b01,
        FN_PIXEL = 2'b10,
        FN_PHASE = 2'b11
    } sya_func_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b10
    } sya_state_t;

    // Sync pins, one bit each
    typedef struct packed {
        logic sog;
        logic composite_sync_vs;
        logic analog_video_input_vs;
        logic analog_video_input_hs;
        logic dvi_vs;
        logic dvi_hs;
    } sya_sync_t;

    // Sampled pixel stream from the input interface
    typedef struct packed {
        logic valid;
        logic sof;
        logic sol;
        logic de;
        logic [23:0] rgb;
    } sya_pix_t;
endpackage

// >>> src/sya_top.sv
// Sync activity monitor and auto-adjustment engine with active area detection
// Notes on behaviour
// RULE1 - Watch digital and analog hsync and vsync
// RULE2 - Always watch slicer vsync and sync-on-green
// RULE3 - Activity changes raise individually maskable interrupts
// RULE4 - Writing one to clear bit clears pendings
// RULE5 - One means active, enabled, or pending
// RULE6 - Line PLL lock flag readable beside activity
// RULE7 - Two-bit select picks one of four functions
// RULE8 - All functions share one programming field set
// RULE9 - Control write arms, start at next frame
// RULE10 - Run for interval frames, then completion interrupt
// RULE11 - Area interval: 1, 4, 8, until change
// RULE12 - Above start threshold marks upper-left corner
// RULE13 - Above end threshold moves lower-right corner
// RULE14 - Corners held until other function or reinit
// RULE15 - Resampling continues from held corners, only grows
// RULE16 - Enhanced all pixels, else reference row/column
// RULE17 - Variant codes: resample or initial, enhanced or not
// RULE18 - Initial submodes preset corners FFFF and 0000
// RULE19 - Report frame maximum and active-area minimum
// RULE20 - Reported minimum never below lowest threshold
// RULE21 - Data enable select uses digital data enable
// RULE22 - Columns 11, rows 12, colours 24, results 16
// RULE23 - Clear bit sits at offset zero
// RULE24 - Pending set on change, held until cleared
// RULE25 - Control write mid-run abandons and re-arms
module sya_top #(
    parameter int ACT_TIMEOUT = sya_pkg::ACT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sync pins and line PLL lock, asynchronous
    input wire sya_pkg::sya_sync_t sync_pins_i,
    input wire logic line_pll_lock_i,
    // Pixel stream, same clock
    input wire sya_pkg::sya_pix_t pix_i,
    // Event outputs
    output logic sync_int_o,
    output logic adjust_done_int_o,
    output logic adjust_busy_o
);
    import sya_pkg::*;

    // Merge write data into a register through byte enables
    function automatic logic [31:0] sya_wr(input logic [31:0] old);
        logic [31:0] m;
        m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        return (old & ~m) | (wb_dat_i & m);
    endfunction

    // Bus strobes
    logic ack_r;
    logic bus_req;
    logic wr_en;
    logic clear_int;
    logic adjust_wr;
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_en = bus_req & wb_we_i;
    assign clear_int = wr_en && wb_adr_i == REG_DETECT_CTRL && wb_sel_i[0] && wb_dat_i[CLEAR_INT_BIT]; // RULE4 RULE23
    assign adjust_wr = wr_en && wb_adr_i == REG_ADJUST_CTRL && wb_sel_i != 4'h0;

    // Software registers
    logic [31:0] int_en_r;
    logic [31:0] input_sync_r;
    logic [31:0] adjust_ctrl_r;
    logic [31:0] ref_pos0_r;
    logic [31:0] ref_pos1_r;
    logic [31:0] ref_colour0_r;
    logic [31:0] ref_colour1_r;

    // Configuration writes; one shared field set serves every function
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_en_r <= 32'h0000_0000;
            input_sync_r <= 32'h0000_0000;
            adjust_ctrl_r <= 32'h0000_0000;
            ref_pos0_r <= 32'h0000_0000;
            ref_pos1_r <= 32'h0000_0000;
            ref_colour0_r <= 32'h0000_0000;
            ref_colour1_r <= 32'h0000_0000;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                REG_SYNC_INT_EN: int_en_r <= sya_wr(int_en_r) & MASK_INT_EN; // RULE3
                REG_INPUT_SYNC_CTRL: input_sync_r <= sya_wr(input_sync_r) & MASK_INPUT_SYNC;
                REG_ADJUST_CTRL: adjust_ctrl_r <= sya_wr(adjust_ctrl_r) & MASK_ADJUST; // RULE8
                REG_REF_POS0: ref_pos0_r <= sya_wr(ref_pos0_r) & MASK_REF_POS; // RULE22
                REG_REF_POS1: ref_pos1_r <= sya_wr(ref_pos1_r) & MASK_REF_POS;
                REG_REF_COLOUR0: ref_colour0_r <= sya_wr(ref_colour0_r) & MASK_COLOUR;
                REG_REF_COLOUR1: ref_colour1_r <= sya_wr(ref_colour1_r) & MASK_COLOUR;
                default: ;
            endcase
        end
    end

    // Decoded control fields
    sya_func_t func;
    logic [1:0] variant;
    logic [1:0] interval;
    logic [10:0] ref_col0;
    logic [11:0] ref_row0;
    logic use_de;
    assign func = sya_func_t'(adjust_ctrl_r[FN_LSB +: 2]); // RULE7
    assign variant = adjust_ctrl_r[VAR_LSB +: 2];
    assign interval = adjust_ctrl_r[IVL_LSB +: 2];
    assign ref_col0 = ref_pos0_r[REF_COL_LSB +: 11];
    assign ref_row0 = ref_pos0_r[REF_ROW_LSB +: 12];
    assign use_de = input_sync_r[USE_DE_BIT];

    // Pin synchronisers; stage one feeds stage two only
    logic [NUM_SYNC:0] pin_s1_r;
    logic [NUM_SYNC:0] pin_s2_r;
    logic [NUM_SYNC-1:0] sync_s3_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            sync_s3_r <= '0;
        end else begin
            pin_s1_r <= {line_pll_lock_i, sync_pins_i};
            pin_s2_r <= pin_s1_r;
            sync_s3_r <= pin_s2_r[NUM_SYNC-1:0];
        end
    end

    // Activity watchdogs; active while edges come within the timeout
    logic [NUM_SYNC-1:0] active_r;
    logic [NUM_SYNC-1:0] active_prev_r;
    logic [NUM_SYNC-1:0] pend_r;
    genvar g;
    generate
        for (g = 0; g < NUM_SYNC; g++) begin : g_act
            logic [ACT_CNT_W-1:0] cnt_r;
            logic edge_seen;
            assign edge_seen = pin_s2_r[g] ^ sync_s3_r[g];
            // Per input, held at the timeout until the next edge, independent of the selected source
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt_r <= '0;
                    active_r[g] <= 1'b0;
                end else if (edge_seen) begin
                    cnt_r <= '0;
                    active_r[g] <= 1'b1; // RULE1 RULE2
                end else if (cnt_r == ACT_CNT_W'(ACT_TIMEOUT - 1)) begin
                    active_r[g] <= 1'b0;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    endgenerate

    // Pending flags; a change in the clear cycle still sets the flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_prev_r <= '0;
            pend_r <= '0;
        end else begin
            active_prev_r <= active_r;
            pend_r <= ((clear_int ? '0 : pend_r) | ((active_r ^ active_prev_r) & int_en_r[NUM_SYNC-1:0])); // RULE24 RULE3
        end
    end

    // Pixel coordinates of the current sample
    logic [COORD_W-1:0] col_r;
    logic [COORD_W-1:0] row_r;
    logic [COORD_W-1:0] cur_col;
    logic [COORD_W-1:0] cur_row;
    always_comb begin
        cur_col = (pix_i.sof | pix_i.sol) ? '0 : col_r + 1'b1;
        cur_row = pix_i.sof ? '0 : (pix_i.sol ? row_r + 1'b1 : row_r);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_r <= '0;
            row_r <= '0;
        end else if (pix_i.valid) begin
            col_r <= cur_col;
            row_r <= cur_row;
        end
    end

    // Adjustment sequencer
    sya_state_t state_r;
    logic [4:0] frames_left_r;
    logic changed_r;
    logic done_pend_r;
    logic frame_start;
    logic start;
    logic finish;
    logic init_vals;
    logic until_change;
    logic [4:0] frames_req;
    assign frame_start = pix_i.valid & pix_i.sof;
    assign start = state_r == ST_ARMED && frame_start && !adjust_wr; // RULE9
    assign until_change = func == FN_AREA && interval == 2'h3;
    assign finish = state_r == ST_RUN && frame_start && !adjust_wr &&
                    (until_change ? changed_r : frames_left_r == FRAMES_1); // RULE10 RULE11
    assign init_vals = start && (func != FN_AREA || variant[VAR_INIT_BIT]); // RULE14 RULE17
    always_comb begin
        unique case (interval)
            IVL_ONE: frames_req = FRAMES_1;
            IVL_FOUR: frames_req = FRAMES_4;
            IVL_EIGHT: frames_req = FRAMES_8;
            default: frames_req = FRAMES_16; // Unused count in until-change mode
        endcase
    end

    // State and frame counting; a write always re-arms
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            frames_left_r <= '0;
        end else if (adjust_wr) begin
            state_r <= ST_ARMED; // RULE9 RULE25
        end else begin
            unique case (state_r)
                ST_IDLE: ;
                ST_ARMED: begin
                    if (start) begin
                        state_r <= ST_RUN;
                        frames_left_r <= frames_req;
                    end
                end
                ST_RUN: begin
                    if (finish) begin
                        state_r <= ST_IDLE;
                    end else if (frame_start) begin
                        frames_left_r <= frames_left_r - 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Completion flag; setting beats a simultaneous clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_pend_r <= 1'b0;
        end else if (finish && adjust_ctrl_r[DONE_EN_BIT]) begin
            done_pend_r <= 1'b1; // RULE10
        end else if (clear_int) begin
            done_pend_r <= 1'b0; // RULE23
        end
    end

    // Area results and colour extremes
    logic [COORD_W-1:0] ul_col_r;
    logic [COORD_W-1:0] ul_row_r;
    logic [COORD_W-1:0] lr_col_r;
    logic [COORD_W-1:0] lr_row_r;
    logic [23:0] max_rgb_r;
    logic [23:0] min_rgb_r;
    logic [COORD_W-1:0] ul_col_b;
    logic [COORD_W-1:0] ul_row_b;
    logic [COORD_W-1:0] lr_col_b;
    logic [COORD_W-1:0] lr_row_b;
    logic [23:0] max_b;
    logic [23:0] min_b;
    logic eval_en;
    logic in_win;
    logic hit_ul;
    logic hit_lr;
    logic above0;
    logic above1;
    logic [NUM_COMP-1:0][COMP_W-1:0] px, th0, th1;
    logic [23:0] max_n;
    logic [23:0] min_n;
    logic [COORD_W-1:0] ul_col_nxt;
    logic [COORD_W-1:0] ul_row_nxt;
    logic [COORD_W-1:0] lr_col_nxt;
    logic [COORD_W-1:0] lr_row_nxt;

    // One pixel against thresholds and running results
    always_comb begin
        ul_col_b = init_vals ? COORD_INIT_UL : ul_col_r; // RULE18
        ul_row_b = init_vals ? COORD_INIT_UL : ul_row_r;
        lr_col_b = init_vals ? COORD_INIT_LR : lr_col_r;
        lr_row_b = init_vals ? COORD_INIT_LR : lr_row_r; // RULE15
        max_b = start ? {NUM_COMP{COMP_MAX_INIT}} : max_rgb_r;
        min_b = start ? {NUM_COMP{COMP_MIN_INIT}} : min_rgb_r;
        eval_en = pix_i.valid && func == FN_AREA && (start || (state_r == ST_RUN && !finish)) && !adjust_wr;
        in_win = !variant[VAR_NONENH_BIT] ||
                 cur_row == COORD_W'(ref_row0) || cur_col == COORD_W'(ref_col0); // RULE16
        {px, th0, th1} = {pix_i.rgb, 24'(ref_colour0_r), 24'(ref_colour1_r)};
        above0 = 1'b0;
        above1 = 1'b0;
        for (int c = 0; c < NUM_COMP; c++) begin
            if (px[c] > th0[c]) begin
                above0 = 1'b1; // RULE12
            end
            if (px[c] > th1[c]) begin
                above1 = 1'b1; // RULE13
            end
        end
        hit_ul = in_win && (use_de ? pix_i.de : above0); // RULE21
        hit_lr = in_win && (use_de ? pix_i.de : above1);
        max_n = max_b;
        min_n = min_b;
        for (int c = 0; c < NUM_COMP; c++) begin
            if (px[c] > max_b[c*COMP_W +: COMP_W]) begin
                max_n[c*COMP_W +: COMP_W] = px[c]; // RULE19
            end
            if (hit_ul && px[c] < min_b[c*COMP_W +: COMP_W]) begin
                min_n[c*COMP_W +: COMP_W] = px[c];
            end
        end
        // Corners only widen, so resampling never shrinks the area
        ul_col_nxt = (hit_ul && cur_col < ul_col_b) ? cur_col : ul_col_b; // RULE12 RULE15
        ul_row_nxt = (hit_ul && cur_row < ul_row_b) ? cur_row : ul_row_b;
        lr_col_nxt = (hit_lr && cur_col > lr_col_b) ? cur_col : lr_col_b; // RULE13
        lr_row_nxt = (hit_lr && cur_row > lr_row_b) ? cur_row : lr_row_b;
    end

    // Result registers; other functions start from clean values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ul_col_r <= COORD_INIT_UL;
            ul_row_r <= COORD_INIT_UL;
            lr_col_r <= COORD_INIT_LR;
            lr_row_r <= COORD_INIT_LR;
            max_rgb_r <= {NUM_COMP{COMP_MAX_INIT}};
            min_rgb_r <= {NUM_COMP{COMP_MIN_INIT}};
        end else if (eval_en) begin
            ul_col_r <= ul_col_nxt;
            ul_row_r <= ul_row_nxt;
            lr_col_r <= lr_col_nxt;
            lr_row_r <= lr_row_nxt;
            max_rgb_r <= max_n;
            min_rgb_r <= min_n;
        end else if (start) begin
            ul_col_r <= ul_col_b; // RULE14
            ul_row_r <= ul_row_b;
            lr_col_r <= lr_col_b;
            lr_row_r <= lr_row_b;
            max_rgb_r <= max_b;
            min_rgb_r <= min_b;
        end
    end

    // Change tracking for the until-change interval
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            changed_r <= 1'b0;
        end else if (start) begin
            changed_r <= 1'b0;
        end else if (eval_en && {ul_col_nxt, ul_row_nxt, lr_col_nxt, lr_row_nxt} !=
                     {ul_col_r, ul_row_r, lr_col_r, lr_row_r}) begin
            changed_r <= 1'b1; // RULE11
        end
    end

    // Minimum clamped to the lower threshold per component
    logic [NUM_COMP-1:0][COMP_W-1:0] min_rep;
    always_comb begin
        min_rep = min_rgb_r;
        for (int c = 0; c < NUM_COMP; c++) begin
            if (min_rep[c] < th0[c] && min_rep[c] < th1[c]) begin
                min_rep[c] = (th0[c] < th1[c]) ? th0[c] : th1[c]; // RULE20
            end
        end
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            REG_SYNC_STATUS: rd_data = 32'({pin_s2_r[NUM_SYNC], active_r}); // RULE5 RULE6
            REG_SYNC_INT_EN: rd_data = int_en_r;
            REG_SYNC_INT_PEND: rd_data = 32'(pend_r); // RULE5
            REG_INPUT_SYNC_CTRL: rd_data = input_sync_r;
            REG_ADJUST_CTRL: rd_data = adjust_ctrl_r | (32'(state_r != ST_IDLE) << BUSY_BIT) |
                                       (32'(done_pend_r) << DONE_PEND_BIT);
            REG_REF_POS0: rd_data = ref_pos0_r;
            REG_REF_POS1: rd_data = ref_pos1_r;
            REG_REF_COLOUR0: rd_data = ref_colour0_r;
            REG_REF_COLOUR1: rd_data = ref_colour1_r;
            REG_EVAL0: rd_data = {ul_row_r, ul_col_r}; // RULE22
            REG_EVAL1: rd_data = {lr_row_r, lr_col_r};
            REG_PIXEL0: rd_data = 32'(max_rgb_r); // RULE19
            REG_PIXEL1: rd_data = 32'(min_rep);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_r;

    // Registered event outputs, one cycle behind their flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_int_o <= 1'b0;
            adjust_done_int_o <= 1'b0;
            adjust_busy_o <= 1'b0;
        end else begin
            sync_int_o <= |pend_r; // RULE3
            adjust_done_int_o <= done_pend_r;
            adjust_busy_o <= state_r != ST_IDLE;
        end
    end
endmodule

// >>> tb/sya_props.sv
// Port-level checker for the sync activity and area detect block
module sya_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sync_int_o,
    input wire logic adjust_done_int_o,
    input wire logic adjust_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req;
    logic arm;
    logic clr;
    // Decoded requests; a held request stays visible in its ack cycle
    assign req = wb_cyc_i && wb_stb_i;
    assign arm = req && wb_we_i && wb_adr_i == 8'h14;
    assign clr = req && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_LAT: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data out of ack");
    AST_CTRL_RD: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o == 32'h0000_0000)
        else $error("clear register not zero");
    AST_ARM_BUSY: assert property (arm && !wb_ack_o |-> ##2 adjust_busy_o) else $error("not armed");
    AST_BUSY_CAUSE: assert property ($rose(adjust_busy_o) |-> $past(arm) || $past(arm, 2))
        else $error("busy without arm");
    AST_DONE_END: assert property ($rose(adjust_done_int_o) |-> $fell(adjust_busy_o))
        else $error("done not at run end");
    AST_SYNC_HOLD: assert property (sync_int_o && !clr |=> sync_int_o) else $error("sync flag lost");
    AST_DONE_HOLD: assert property (adjust_done_int_o && !clr |=> adjust_done_int_o)
        else $error("done flag lost");
    // Idle engine: a clear shows two cycles on
    AST_DONE_CLR: assert property (clr && !wb_ack_o && !adjust_busy_o && !$past(adjust_busy_o)
        |-> ##2 !adjust_done_int_o) else $error("done not cleared");
endmodule

bind sya_top sya_props sya_props_i (.*);

// >>> tb/sya_src.sv
// Video source model: raster pixel stream and toggling sync pins
module sya_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [5:0] act_i,
    output sya_pkg::sya_pix_t pix_o,
    output sya_pkg::sya_sync_t sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sya_pkg::*;
    logic [3:0] col_r;
    logic [3:0] row_r;
    logic [2:0] tick_r;
    logic [23:0] last_r;
    logic rect;
    logic lit;
    // Lit block 3..10 x 2..8 plus one stray pixel off the reference cross
    assign rect = col_r >= 4'h3 && col_r <= 4'hA && row_r >= 4'h2 && row_r <= 4'h8;
    assign lit = rect || (col_r == 4'hD && row_r == 4'hA);
    // Raster of 16 x 12, advancing only while running
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            col_r <= 4'h0;
            row_r <= 4'h0;
        end else begin
            col_r <= col_r + 4'h1;
            if (col_r == 4'hF) begin
                row_r <= (row_r == 4'hB) ? 4'h0 : row_r + 4'h1;
            end
        end
    end
    // Idle bus shows the inverse of the last word
    always_comb begin
        pix_o.valid = run_i;
        pix_o.sof = run_i && col_r == 4'h0 && row_r == 4'h0;
        pix_o.sol = run_i && col_r == 4'h0;
        pix_o.de = run_i && rect;
        pix_o.rgb = !run_i ? ~last_r : lit ? 24'h80_90A0 : 24'h10_2030;
    end
    // Syncs stand still unless asked to toggle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_r <= 3'h0;
            sync_o <= '0;
            last_r <= 24'h00_0000;
        end else begin
            tick_r <= tick_r + 3'h1;
            sync_o <= sya_sync_t'(sync_o ^ (act_i & {6{tick_r == 3'h0}}));
            last_r <= run_i ? pix_o.rgb : last_r;
        end
    end
endmodule

// >>> tb/tb_sya_top.sv
// Register-level testbench for the sync activity and area detect block
module tb_sya_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sya_pkg::*;
    localparam int TO = 64;
    localparam int F = 192;
    logic clk_i, rst_i, cyc, stb, we, run, lock, ack, sint, dint, busy;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, dat_o;
    logic [5:0] act;
    sya_sync_t pins;
    sya_pix_t pix;
    int err_total, comparisons, n, cnt, nf;
    logic [1:0] vs [3] = '{2'h3, 2'h0, 2'h1};
    logic [31:0] ve [3] = '{32'h0008_000A, 32'h000A_000D, 32'h000A_000D};
    sya_top #(.ACT_TIMEOUT(TO)) sya_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .sync_pins_i(pins), .line_pll_lock_i(lock), .pix_i(pix), .sync_int_o(sint),
        .adjust_done_int_o(dint), .adjust_busy_o(busy));
    sya_src sya_src_i (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .act_i(act), .pix_o(pix), .sync_o(pins));
    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // Hold the request until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            err_total++;
            conclude();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask
    // Arm, then count cycles until idle
    task automatic run_adj(input logic [31:0] ctl);
        wb(1'b1, REG_ADJUST_CTRL, ctl);
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
        end while ((busy !== 1'b0 || cnt < 4) && cnt < 4000);
        if (cnt >= 4000) begin
            err_total++;
            conclude();
        end
    endtask
    initial begin
        {err_total, comparisons} = '0;
        {cyc, stb, we, run, adr, wdat, act} = '0;
        lock = 1'b1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_SYNC_INT_EN, 32'h0000_0000);
        rd(REG_EVAL0, 32'hFFFF_FFFF);
        wb(1'b1, REG_SYNC_INT_EN, 32'hFFFF_FFFD);
        rd(REG_SYNC_INT_EN, 32'h0000_003D);
        rd(8'h40, 32'h0000_0000);
        run <= 1'b1;
        act <= 6'h3F;
        repeat (40) @(posedge clk_i);
        rd(REG_SYNC_STATUS, 32'h0000_007F);
        rd(REG_SYNC_INT_PEND, 32'h0000_003D);
        chk(32'(sint), 32'h1);
        wb(1'b1, REG_DETECT_CTRL, 32'h0000_0001);
        rd(REG_SYNC_INT_PEND, 32'h0000_0000);
        act <= 6'h00;
        lock <= 1'b0;
        repeat (TO + 40) @(posedge clk_i);
        rd(REG_SYNC_STATUS, 32'h0000_0000);
        rd(REG_SYNC_INT_PEND, 32'h0000_003D);
        wb(1'b1, REG_DETECT_CTRL, 32'h0000_0001);
        wb(1'b1, REG_REF_COLOUR0, 32'h0040_4040);
        wb(1'b1, REG_REF_COLOUR1, 32'h0040_4040);
        wb(1'b1, REG_REF_POS0, 32'h0004_0005);
        // Every interval code, initial-value enhanced area detect
        for (int i = 0; i < 4; i++) begin
            run_adj(32'h48 | (i << 4));
            nf = i == 1 ? 4 : i == 2 ? 8 : 1;
            chk(32'(cnt >= nf * F && cnt <= (nf + 1) * F + 4), 32'h1);
        end
        chk(32'(dint), 32'h1);
        rd(REG_ADJUST_CTRL, 32'h0000_0278);
        rd(REG_EVAL0, 32'h0002_0003);
        rd(REG_EVAL1, 32'h000A_000D);
        rd(REG_PIXEL0, 32'h0080_90A0);
        rd(REG_PIXEL1, 32'h0080_90A0);
        wb(1'b1, REG_DETECT_CTRL, 32'h0000_0001);
        rd(REG_ADJUST_CTRL, 32'h0000_0078);
        // Non-enhanced, then resampling growth and hold
        for (int k = 0; k < 3; k++) begin
            run_adj(32'(vs[k]) << 2);
            rd(REG_EVAL1, ve[k]);
            rd(REG_EVAL0, 32'h0002_0003);
        end
        wb(1'b1, REG_INPUT_SYNC_CTRL, 32'h0000_0001);
        run_adj(32'h0000_0008);
        rd(REG_EVAL1, 32'h0008_000A);
        wb(1'b1, REG_INPUT_SYNC_CTRL, 32'h0000_0000);
        for (int f = 1; f < 4; f++) begin
            run_adj(32'(f));
            rd(REG_EVAL0, 32'hFFFF_FFFF);
            rd(REG_EVAL1, 32'h0000_0000);
        end
        // Rewrite mid-run abandons the eight-frame run
        wb(1'b1, REG_ADJUST_CTRL, 32'h0000_0020);
        repeat (400) @(posedge clk_i);
        run_adj(32'h0000_0000);
        chk(32'(cnt <= 2 * F + 4), 32'h1);
        conclude();
    end
endmodule
